// >>> core/asfi_frame.v
`timescale 1ns/1ps
`include "asfi_regs.vh"

module asfi_frame (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        nrst,
  // Serial pins
  input  wire        cs_n,
  input  wire        sclk,
  input  wire        sdi,
  output wire        sdo,
  output wire        sdo_oe,
  output wire        frame_ready_strobe,
  // Conversion result from converter logic
  input  wire [15:0] conv_result,
  input  wire        conv_done,
  // Configuration
  input  wire [2:0]  test_pattern_select,
  input  wire        parity_enable,
  input  wire [1:0]  partial_parity_span,
  input  wire        read_on_internal_clock,
  // Register access
  input  wire [7:0]  reg_rd_data,
  output wire [7:0]  reg_rd_addr,
  output wire        reg_wr_en,
  output wire [7:0]  reg_wr_addr,
  output wire [7:0]  reg_wr_data,
  // Decoded command
  output wire        cmd_valid,
  output wire [19:0] cmd_word
);

  reg        cs_s1_q;
  reg        cs_s2_q;
  reg        cs_s3_q;
  reg        ck_s1_q;
  reg        ck_s2_q;
  reg        ck_s3_q;
  reg        di_s1_q;
  reg        di_s2_q;
  reg [19:0] odr_q;
  reg [19:0] idr_q;
  reg [4:0]  cnt_q;
  reg        oe_q;
  reg        rdy_q;
  reg [3:0]  dly_q;
  reg        dly_run_q;
  reg [15:0] result_q;
  reg        rd_pend_q;
  reg [7:0]  rd_addr_q;
  reg        wr_en_q;
  reg [7:0]  wr_addr_q;
  reg [7:0]  wr_data_q;
  reg        cmd_valid_q;
  reg [19:0] cmd_word_q;
  reg [2:0]  div_q;

  wire cs_fall  = cs_s3_q & ~cs_s2_q;
  wire cs_rise  = ~cs_s3_q & cs_s2_q;
  wire in_frame = ~cs_s2_q & ~cs_s3_q;
  wire ck_rise  = ~ck_s3_q & ck_s2_q;
  wire ck_fall  = ck_s3_q & ~ck_s2_q;
  wire int_tick = (div_q == `ASFI_DIV_LAST);
  // Launch edge follows chosen read clock
  wire launch   = in_frame & (read_on_internal_clock ? int_tick : ck_fall);
  wire capture  = in_frame & ck_rise;
  wire full     = (cnt_q >= `ASFI_CNT_FULL);
  wire op_write = (idr_q[19:16] == `ASFI_OP_WRITE);
  wire op_read  = (idr_q[19:16] == `ASFI_OP_READ);

  // Output data word assembly
  reg [15:0] upper;
  reg [19:0] word;
  reg        span_par;
  reg        full_par;
  always @* begin
    upper = (test_pattern_select[`ASFI_PATN_FIXED]) ? `ASFI_FIXED_PATTERN : result_q;
    full_par = ^upper;
    case (partial_parity_span)
      `ASFI_SPAN_4:  span_par = ^upper[15:12];
      `ASFI_SPAN_8:  span_par = ^upper[15:8];
      `ASFI_SPAN_12: span_par = ^upper[15:4];
      default:       span_par = ^upper;
    endcase
    if (rd_pend_q) begin
      word = {reg_rd_data, `ASFI_ZERO12};
    end else if (parity_enable) begin
      word = {upper, full_par, span_par, `ASFI_ZERO2};
    end else begin
      word = {upper, `ASFI_ZERO2, `ASFI_ZERO2};
    end
  end

  // Pin synchronisers
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_s3_q <= 1'b0;
      di_s1_q <= 1'b0;
      di_s2_q <= 1'b0;
    end else begin
      cs_s1_q <= cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      ck_s1_q <= sclk;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
      di_s1_q <= sdi;
      di_s2_q <= di_s1_q;
    end
  end

  // Latest conversion result, next state
  reg [15:0] result_d;
  always @* begin
    result_d = result_q;
    if (conv_done) begin
      result_d = conv_result;
    end
  end

  // Latest conversion result, replaced on every conv_done
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      result_q <= 16'h0000;
    end else begin
      result_q <= result_d;
    end
  end

  // Internal read clock divider
  reg [2:0]  div_d;
  always @* begin
    div_d = div_q + 3'h1;
    if (!in_frame || int_tick) begin
      div_d = 3'h0;
    end
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_d;
    end
  end

  // Frame shifters and counter, next state
  reg [19:0] odr_d;
  reg [19:0] idr_d;
  reg [4:0]  cnt_d;
  reg        oe_d;
  always @* begin
    odr_d = odr_q;
    idr_d = idr_q;
    cnt_d = cnt_q;
    oe_d  = oe_q;
    if (cs_fall) begin
      odr_d = word;
      idr_d = `ASFI_IDR_CLEAR;
      cnt_d = 5'h00;
      oe_d  = 1'b1;
    end else if (cs_rise) begin
      oe_d  = 1'b0;
    end else begin
      if (capture) begin
        idr_d = {idr_q[18:0], di_s2_q};
        if (!full) begin
          cnt_d = cnt_q + `ASFI_CNT_ONE;
        end
      end
      if (launch) begin
        odr_d = {odr_q[18:0], 1'b0};
      end
    end
  end

  // Frame shifters and counter registers
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      odr_q <= 20'h00000;
      idr_q <= `ASFI_IDR_CLEAR;
      cnt_q <= 5'h00;
      oe_q  <= 1'b0;
    end else begin
      odr_q <= odr_d;
      idr_q <= idr_d;
      cnt_q <= cnt_d;
      oe_q  <= oe_d;
    end
  end

  // Command decode at frame end
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_pend_q   <= 1'b0;
      rd_addr_q   <= 8'h00;
      wr_en_q     <= 1'b0;
      wr_addr_q   <= 8'h00;
      wr_data_q   <= 8'h00;
      cmd_valid_q <= 1'b0;
      cmd_word_q  <= `ASFI_NOP_WORD;
    end else begin
      wr_en_q     <= 1'b0;
      cmd_valid_q <= 1'b0;
      if (cs_fall) begin
        rd_pend_q <= 1'b0;
      end else if (cs_rise && full) begin
        cmd_valid_q <= 1'b1;
        cmd_word_q  <= idr_q;
        if (op_write) begin
          wr_en_q   <= 1'b1;
          wr_addr_q <= idr_q[15:8];
          wr_data_q <= idr_q[7:0];
        end else if (op_read) begin
          rd_pend_q <= 1'b1;
          rd_addr_q <= idr_q[15:8];
        end
      end
    end
  end

  // Ready strobe next state
  reg        rdy_d;
  reg [3:0]  dly_d;
  reg        dly_run_d;
  always @* begin
    rdy_d     = rdy_q;
    dly_d     = dly_q;
    dly_run_d = dly_run_q;
    if (cs_fall || in_frame) begin
      rdy_d     = 1'b0;
      dly_run_d = 1'b0;
    end else if (cs_rise) begin
      dly_run_d = 1'b1;
      if (full && op_write) begin
        dly_d = `ASFI_RDY_WR_LOAD;
      end else begin
        dly_d = `ASFI_RDY_NOP_LOAD;
      end
    end else if (dly_run_q) begin
      if (dly_q == 4'h0) begin
        rdy_d     = 1'b1;
        dly_run_d = 1'b0;
      end else begin
        dly_d = dly_q - 4'h1;
      end
    end
  end

  // Ready strobe registers
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdy_q     <= 1'b1;
      dly_q     <= 4'h0;
      dly_run_q <= 1'b0;
    end else begin
      rdy_q     <= rdy_d;
      dly_q     <= dly_d;
      dly_run_q <= dly_run_d;
    end
  end

  assign sdo                = odr_q[`ASFI_MSB];
  assign sdo_oe             = oe_q;
  assign frame_ready_strobe = rdy_q;
  assign reg_rd_addr        = rd_addr_q;
  assign reg_wr_en          = wr_en_q;
  assign reg_wr_addr        = wr_addr_q;
  assign reg_wr_data        = wr_data_q;
  assign cmd_valid          = cmd_valid_q;
  assign cmd_word           = cmd_word_q;

endmodule

// >>> pkg/asfi_regs.vh
`ifndef ASFI_REGS_VH
`define ASFI_REGS_VH

// Word layout
`define ASFI_WORD_W        20
`define ASFI_MSB           19
`define ASFI_RES_HI        19
`define ASFI_RES_LO        4
`define ASFI_REG_LO        12
`define ASFI_FULL_WORD_PARITY_BIT     3
`define ASFI_PARTIAL_WORD_PARITY_BIT     2
`define ASFI_IDR_CLEAR     20'h00000
`define ASFI_ZERO12        12'h000
`define ASFI_ZERO2         2'h0

// Frame length
`define ASFI_CNT_W         5
`define ASFI_CNT_FULL      5'h14
`define ASFI_CNT_ONE       5'h01

// Command codes in bits 19:16
`define ASFI_OP_WRITE      4'ha
`define ASFI_OP_READ       4'h1
`define ASFI_NOP_WORD      20'hfffff

// Configuration field codes
`define ASFI_PATN_FIXED    2
`define ASFI_SPAN_4        2'h0
`define ASFI_SPAN_8        2'h1
`define ASFI_SPAN_12       2'h2

// Fixed test pattern (arbitrary value)
`define ASFI_FIXED_PATTERN 16'ha5c3

// Timing
`define ASFI_CLK_NS        50
`define ASFI_RDY_NOP_NS    100
`define ASFI_RDY_WR_NS     300
`define ASFI_RDY_NOP_CYC   ((`ASFI_RDY_NOP_NS + `ASFI_CLK_NS - 1) / `ASFI_CLK_NS)
`define ASFI_RDY_WR_CYC    ((`ASFI_RDY_WR_NS + `ASFI_CLK_NS - 1) / `ASFI_CLK_NS)
`define ASFI_DLY_W         4
`define ASFI_INT_DIV       4
`define ASFI_DIV_W         3
`define ASFI_DIV_LAST      3'h3
`define ASFI_RDY_NOP_LOAD  4'h1
`define ASFI_RDY_WR_LOAD   4'h5

`endif

// >>> testbench/adc_serial_frame_interface_tb_top.sv
`timescale 1ns/1ps
module adc_serial_frame_interface_tb_top;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cs_n, sclk, sdi, sdo, sdo_oe, frame_ready_strobe;
  logic [15:0] conv_result = 16'h0;
  logic        conv_done = 1'b0;
  logic [2:0]  test_pattern_select = 3'h0;
  logic        parity_enable = 1'b0;
  logic [1:0]  partial_parity_span = 2'h0;
  logic        read_on_internal_clock = 1'b0;
  logic [7:0]  reg_rd_addr, reg_wr_addr, reg_wr_data;
  logic        reg_wr_en, cmd_valid;
  logic [19:0] cmd_word;
  wire  [7:0]  reg_rd_data = reg_rd_addr ^ 8'h3c;
  logic [15:0] rs = 16'hd28b;
  int          miscompares = 0;
  int          n_tests = 0;
  int          nv = 0;
  int          nw = 0;
  asfi_frame u_dut (.ref_clk, .nrst, .cs_n, .sclk, .sdi, .sdo, .sdo_oe, .frame_ready_strobe, .conv_result,
    .conv_done, .test_pattern_select, .parity_enable, .partial_parity_span, .read_on_internal_clock,
    .reg_rd_data, .reg_rd_addr, .reg_wr_en, .reg_wr_addr, .reg_wr_data, .cmd_valid, .cmd_word);
  asfi_host u_host (.ref_clk, .cs_n, .sclk, .sdi, .sdo, .frame_ready_strobe);
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    nv += (cmd_valid === 1'b1);
    nw += (reg_wr_en === 1'b1);
  end
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [19:0] word(input logic [15:0] r, input logic [2:0] p, input logic pe,
                                       input logic [1:0] sp);
    logic [15:0] d;
    d = p[2] ? 16'ha5c3 : r;
    return {d, pe & ^d, pe & ^(d & (16'hffff << (12 - 4 * sp))), 2'h0};
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #1000000;
    miscompares++;
    end_of_test();
  end
  initial begin
    logic [23:0] tx, rx;
    logic [19:0] ew, cw;
    logic [7:0]  ra;
    logic [3:0]  op;
    logic        rd;
    int          n, k, v0, w0;
    cw = 20'hfffff;
    ra = 8'h0;
    rd = 1'b0;
    repeat (12) @(posedge ref_clk);
    #1 nrst = 1'b1;
    u_host.cyc(4);
    for (int i = 0; i < 40; i++) begin
      rs = nxt(rs);
      conv_result = rs;
      conv_done = 1'b1;
      u_host.cyc(1);
      conv_done = 1'b0;
      rs = nxt(rs);
      {partial_parity_span, parity_enable, test_pattern_select} = rs[5:0];
      read_on_internal_clock = (i % 8 == 7);
      n = 16 + 4 * (i % 3);
      op = (i % 4 == 0) ? 4'ha : (i % 4 == 1) ? 4'h1 : 4'h5;
      tx = (i % 4 == 2) ? 24'h0fffff : {rs[7:4], op, rs};
      ew = rd ? {ra ^ 8'h3c, 12'h0} : word(conv_result, test_pattern_select, parity_enable, partial_parity_span);
      v0 = nv;
      w0 = nw;
      u_host.xfer(n, tx, rx);
      k = (n < 20) ? n : 20;
      if (!read_on_internal_clock)
        chk(rx >> (n - k), {4'h0, ew} >> (20 - k));
      k = 0;
      while (frame_ready_strobe !== 1'b1 && k < 40) begin
        u_host.cyc(1);
        k++;
      end
      if (n >= 20)
        cw = tx[19:0];
      chk(cmd_word, cw);
      chk(24'(nv - v0), n >= 20);
      chk(24'(nw - w0), n >= 20 && cw[19:16] == 4'ha);
      if (n >= 20 && cw[19:16] == 4'ha)
        chk({reg_wr_addr, reg_wr_data}, cw[15:0]);
      rd = (n >= 20 && cw[19:16] == 4'h1);
      ra = cw[15:8];
      if (rd)
        chk(reg_rd_addr, ra);
    end
    end_of_test();
  end
endmodule

// >>> testbench/asfi_chk_sva.sv
`timescale 1ns/1ps
module asfi_chk (
  // Clock and reset
  input logic        ref_clk,
  input logic        nrst,
  // Link
  input logic        cs_n,
  input logic        sclk,
  input logic        sdo,
  input logic        sdo_oe,
  input logic        frame_ready_strobe,
  input logic        read_on_internal_clock,
  // Command
  input logic        reg_wr_en,
  input logic [7:0]  reg_wr_addr,
  input logic [7:0]  reg_wr_data,
  input logic        cmd_valid,
  input logic [19:0] cmd_word
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  rst_val_a: assert property ($rose(nrst) |-> frame_ready_strobe && !sdo_oe && cmd_word == 20'hfffff)
    else $error("bad reset state");
  oe_on_a: assert property ($fell(cs_n) |-> ##[1:6] sdo_oe)
    else $error("sdo not driven");
  strobe_rise_a: assert property ($rose(cs_n) |-> !frame_ready_strobe[*2] ##[1:12] frame_ready_strobe)
    else $error("strobe timing");
  strobe_low_a: assert property (!cs_n[*6] |-> !frame_ready_strobe)
    else $error("strobe high in frame");
  oe_idle_a: assert property (cs_n[*6] |-> !sdo_oe)
    else $error("sdo driven idle");
  sdo_hold_a: assert property ((!cs_n && !read_on_internal_clock && $rose(sclk)) |-> $stable(sdo)[*4])
    else $error("sdo moved without launch");
  cmd_idle_a: assert property (cmd_valid |-> cs_n && !sdo_oe)
    else $error("command inside frame");
  wr_fields_a: assert property (reg_wr_en |=> cmd_word[19:16] == 4'ha && {reg_wr_addr, reg_wr_data} == cmd_word[15:0])
    else $error("write fields");
  cover property (reg_wr_en);
  cover property ($rose(cs_n) ##[1:20] cmd_valid);
  cover property (!cs_n && read_on_internal_clock);
endmodule

bind asfi_frame asfi_chk u_chk (.ref_clk, .nrst, .cs_n, .sclk, .sdo, .sdo_oe, .frame_ready_strobe,
  .read_on_internal_clock, .reg_wr_en, .reg_wr_addr, .reg_wr_data, .cmd_valid, .cmd_word);

// >>> testbench/asfi_host.sv
`timescale 1ns/1ps
module asfi_host (
  // Clock
  input  logic ref_clk,
  // Link
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input  logic sdo,
  input  logic frame_ready_strobe
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // One frame, msb first, sdo sampled late in the high phase
  task automatic xfer(input int n, input logic [23:0] tx, output logic [23:0] rx);
    int k;
    k = 0;
    rx = 24'h0;
    while (frame_ready_strobe !== 1'b1 && k < 100) begin
      cyc(1);
      k++;
    end
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = tx[i];
      cyc(4);
      sclk = 1'b1;
      cyc(4);
      rx = {rx[22:0], sdo};
      sclk = 1'b0;
    end
    cyc(4);
    cs_n = 1'b1;
    sdi = ~sdi;
    cyc(1);
  endtask
endmodule
